// [src/nst_top.v]
// Purpose: nand flash strobe timing engine with apb registers
// Assumes: pclk is the system slow clock; fifo feeds the sequencer
// Notes: strobes move only on half flash period ticks
//
// How it works
// - asymmetric mode: each strobe access takes 2T
// - symmetric mode: access in T, half-T edges
// - flash clock is slow clock over divider
// - boot divider 7 if fuse burned, else 3
// - source mode 1: ready from dedicated input
// - capture delay: four equal programmable units
// - interleaved symmetric data: setup becomes 1.5T
`timescale 1ns/1ps
`include "nst_consts.vh"
module nst_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire boot_clock_select_fuse,
    input wire ready_busy_input,
    input wire [7:0] nand_data_i,
    output reg [7:0] nand_data_o,
    output reg nand_data_oe,
    output reg nand_ce_n,
    output reg nand_cle,
    output reg nand_ale,
    output reg nand_write_strobe_n,
    output reg read_strobe_n,
    output reg flash_clk
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    localparam S_IDLE = 3'h0;
    localparam S_SETUP = 3'h1;
    localparam S_LOW = 3'h2;
    localparam S_HIGH = 3'h3;
    localparam S_HOLD = 3'h4;

    reg [3:0] ctrl_r;
    reg [3:0] div_r;
    reg [1:0] delay_r;
    reg [7:0] rdata_r;
    reg rd_valid_r;
    reg boot_done_r;
    reg [1:0] boot_cnt_r;
    reg fuse_s1_r;
    reg fuse_s2_r;
    reg rb_s1_r;
    reg rb_s2_r;
    reg [7:0] d_s1_r;
    reg [7:0] d_s2_r;
    reg [3:0] cnt_r;
    reg [2:0] st_r;
    reg [2:0] st_nxt;
    reg [3:0] hcnt_r;
    reg [1:0] kind_r;
    reg [7:0] byte_r;
    reg cap_pend_r;
    reg [2:0] cap_cnt_r;

    wire sym;
    wire [1:0] devcnt;
    wire rbmode;
    wire [3:0] div_eff;
    wire [3:0] half_pt;
    wire half_tick;
    wire [3:0] cnt_nxt;
    wire acc_done;
    wire wr_ok;
    wire is_write;
    wire is_read;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_pop;
    wire [9:0] fifo_out;
    wire [4:0] fifo_level;
    wire cmd_push;
    wire nand_ready;
    wire pop_ok;
    wire rdata_read;
    wire cap_fire;
    reg [3:0] setup_h;
    reg [3:0] low_h;
    reg [3:0] cyc_h;
    reg [3:0] hold_h;
    reg [31:0] rd_mux;
    reg map_hit;

    assign sym = ctrl_r[`NST_CTRL_SYM];
    assign devcnt = ctrl_r[`NST_CTRL_DEVCNT_HI:`NST_CTRL_DEVCNT_LO];
    assign rbmode = ctrl_r[`NST_CTRL_RBMODE];

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_s1_r <= 1'b0;
            fuse_s2_r <= 1'b0;
            rb_s1_r <= 1'b0;
            rb_s2_r <= 1'b0;
            d_s1_r <= 8'h00;
            d_s2_r <= 8'h00;
        end else begin
            fuse_s1_r <= boot_clock_select_fuse;
            fuse_s2_r <= fuse_s1_r;
            rb_s1_r <= ready_busy_input;
            rb_s2_r <= rb_s1_r;
            d_s1_r <= nand_data_i;
            d_s2_r <= d_s1_r;
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    assign wr_ok = (paddr != `NST_OFF_CMD) | ~pwrite | fifo_in_ready;
    assign acc_done = psel & penable & pready;
    assign cmd_push = acc_done & pwrite & (paddr == `NST_OFF_CMD);
    assign rdata_read = acc_done & ~pwrite & (paddr == `NST_OFF_RDATA);

    always @* begin
        map_hit = 1'b1;
        rd_mux = 32'h00000000;
        case (paddr)
            `NST_OFF_CTRL: rd_mux = {28'h0000000, ctrl_r};
            `NST_OFF_CLKDIV: rd_mux = {28'h0000000, div_r};
            `NST_OFF_DELAY: rd_mux = {30'h0, delay_r};
            `NST_OFF_CMD: rd_mux = 32'h00000000;
            `NST_OFF_RDATA: rd_mux = {24'h000000, rdata_r};
            `NST_OFF_STATUS: rd_mux = {23'h0, fifo_level, 1'b0, nand_ready, rd_valid_r, (st_r != S_IDLE)};
            default: map_hit = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready & wr_ok;
            pslverr <= psel & penable & ~pready & wr_ok & ~map_hit;
            if (psel & penable & ~pready & wr_ok & ~pwrite) begin
                prdata <= rd_mux;
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------
    // control registers, boot divider
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `NST_CTRL_RST;
            div_r <= `NST_DIV_FUSE_LOW;
            delay_r <= `NST_DELAY_RST;
            boot_done_r <= 1'b0;
            boot_cnt_r <= 2'h0;
        end else begin
            if (!boot_done_r) begin
                boot_cnt_r <= boot_cnt_r + 1'b1;
                if (boot_cnt_r == 2'h2) begin
                    boot_done_r <= 1'b1;
                    div_r <= fuse_s2_r ? `NST_DIV_FUSE_HIGH : `NST_DIV_FUSE_LOW;
                end
            end else if (acc_done & pwrite) begin
                case (paddr)
                    `NST_OFF_CTRL: ctrl_r <= pwdata[3:0];
                    `NST_OFF_CLKDIV: div_r <= pwdata[3:0];
                    `NST_OFF_DELAY: delay_r <= pwdata[1:0];
                    default: ctrl_r <= ctrl_r;
                endcase
            end
        end
    end

    // ----------------------------------------
    // flash clock divider and half ticks
    // ----------------------------------------
    assign div_eff = (div_r < `NST_DIV_MIN) ? `NST_DIV_MIN : div_r;
    assign half_pt = {1'b0, div_eff[3:1]};
    assign half_tick = (cnt_r == half_pt - 4'h1) | (cnt_r == div_eff - 4'h1);
    assign cnt_nxt = (cnt_r >= div_eff - 4'h1) ? 4'h0 : cnt_r + 4'h1;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 4'h0;
            flash_clk <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            flash_clk <= (cnt_nxt < half_pt);
        end
    end

    // ----------------------------------------
    // command fifo
    // ----------------------------------------
    nst_fifo #(
        .W(10),
        .D(16),
        .AW(4)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(cmd_push),
        .in_ready(fifo_in_ready),
        .in_data(pwdata[9:0]),
        .out_valid(fifo_out_valid),
        .out_ready(pop_ok),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    // ----------------------------------------
    // timing selection per mode
    // ----------------------------------------
    assign is_write = (kind_r != `NST_KIND_READ);
    assign is_read = (kind_r == `NST_KIND_READ);
    assign nand_ready = rbmode ? rb_s2_r : 1'b1;
    assign pop_ok = (st_r == S_IDLE) & half_tick & fifo_out_valid
        & ~((fifo_out[9:8] == `NST_KIND_READ) & rd_valid_r);
    assign fifo_pop = pop_ok & fifo_out_valid;

    always @* begin
        if (sym & (devcnt != 2'h0) & (kind_r[1] == 1'b1)) begin
            setup_h = `NST_SETUP_ILV_HALVES;
        end else begin
            setup_h = `NST_SETUP_HALVES;
        end
        if (sym) begin
            cyc_h = `NST_SYM_CYCLE_HALVES;
            low_h = `NST_SYM_LOW_HALVES;
            hold_h = `NST_SYM_HOLD_HALVES;
        end else begin
            cyc_h = `NST_ASYM_CYCLE_HALVES;
            low_h = is_read ? `NST_ASYM_RD_LOW_HALVES : `NST_ASYM_WR_LOW_HALVES;
            hold_h = `NST_ASYM_HOLD_HALVES;
        end
    end

    // ----------------------------------------
    // strobe sequencer
    // ----------------------------------------
    always @* begin
        st_nxt = st_r;
        case (st_r)
            S_IDLE: begin
                if (fifo_pop) begin
                    st_nxt = S_SETUP;
                end
            end
            S_SETUP: begin
                if (half_tick & (hcnt_r >= setup_h - 4'h1) & (is_write | nand_ready)) begin
                    st_nxt = S_LOW;
                end
            end
            S_LOW: begin
                if (half_tick & (hcnt_r >= low_h - 4'h1)) begin
                    st_nxt = S_HIGH;
                end
            end
            S_HIGH: begin
                if (half_tick & (hcnt_r >= cyc_h - low_h - 4'h1)) begin
                    st_nxt = S_HOLD;
                end
            end
            S_HOLD: begin
                if (half_tick & (hcnt_r >= hold_h - 4'h1)) begin
                    st_nxt = S_IDLE;
                end
            end
            default: st_nxt = S_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= S_IDLE;
            hcnt_r <= 4'h0;
            kind_r <= `NST_KIND_CMD;
            byte_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            if (st_nxt != st_r) begin
                hcnt_r <= 4'h0;
            end else if (half_tick & (hcnt_r != 4'hF)) begin
                hcnt_r <= hcnt_r + 4'h1;
            end
            if (fifo_pop) begin
                kind_r <= fifo_out[`NST_CMD_KIND_HI:`NST_CMD_KIND_LO];
                byte_r <= fifo_out[7:0];
            end
        end
    end

    // ----------------------------------------
    // pin outputs
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nand_ce_n <= 1'b1;
            nand_cle <= 1'b0;
            nand_ale <= 1'b0;
            nand_write_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            nand_data_o <= 8'h00;
            nand_data_oe <= 1'b0;
        end else begin
            nand_ce_n <= (st_nxt == S_IDLE);
            nand_cle <= (st_nxt != S_IDLE) & (kind_r == `NST_KIND_CMD) & ~fifo_pop
                | fifo_pop & (fifo_out[9:8] == `NST_KIND_CMD);
            nand_ale <= (st_nxt != S_IDLE) & (kind_r == `NST_KIND_ADDR) & ~fifo_pop
                | fifo_pop & (fifo_out[9:8] == `NST_KIND_ADDR);
            nand_write_strobe_n <= ~((st_nxt == S_LOW) & is_write);
            read_strobe_n <= ~((st_nxt == S_LOW) & is_read);
            nand_data_oe <= (st_nxt != S_IDLE) & is_write & ~fifo_pop
                | fifo_pop & (fifo_out[9:8] != `NST_KIND_READ);
            nand_data_o <= fifo_pop ? fifo_out[7:0] : byte_r;
        end
    end

    // ----------------------------------------
    // read capture behind the delay chain
    // ----------------------------------------
    assign cap_fire = cap_pend_r & (cap_cnt_r == 3'h0);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_pend_r <= 1'b0;
            cap_cnt_r <= 3'h0;
        end else begin
            if ((st_r == S_LOW) & (st_nxt == S_HIGH) & is_read) begin
                cap_pend_r <= 1'b1;
                cap_cnt_r <= {1'b0, delay_r};
            end else if (cap_fire) begin
                cap_pend_r <= 1'b0;
            end else if (cap_pend_r) begin
                cap_cnt_r <= cap_cnt_r - 3'h1;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            if (cap_fire) begin
                rdata_r <= d_s2_r;
                rd_valid_r <= 1'b1;
            end else if (rdata_read) begin
                rd_valid_r <= 1'b0;
            end
        end
    end
endmodule // nst_top

// [common/nst_consts.vh]
// Purpose: constants of the nand strobe timing block
// Assumes: 32-bit apb data, pclk is the system slow clock
// Notes: definitions only
`ifndef NST_CONSTS_VH
`define NST_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define NST_OFF_CTRL 8'h00
`define NST_OFF_CLKDIV 8'h04
`define NST_OFF_DELAY 8'h08
`define NST_OFF_CMD 8'h0C
`define NST_OFF_RDATA 8'h10
`define NST_OFF_STATUS 8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define NST_CTRL_SYM 0
`define NST_CTRL_DEVCNT_LO 1
`define NST_CTRL_DEVCNT_HI 2
`define NST_CTRL_RBMODE 3
`define NST_CMD_KIND_LO 8
`define NST_CMD_KIND_HI 9

// ----------------------------------------
// reset values and dividers
// ----------------------------------------
`define NST_CTRL_RST 4'h0
`define NST_DELAY_RST 2'h0
`define NST_DIV_FUSE_HIGH 4'h7
`define NST_DIV_FUSE_LOW 4'h3
`define NST_DIV_MIN 4'h2

// ----------------------------------------
// access kinds
// ----------------------------------------
`define NST_KIND_CMD 2'h0
`define NST_KIND_ADDR 2'h1
`define NST_KIND_WRITE 2'h2
`define NST_KIND_READ 2'h3

// ----------------------------------------
// timing counts in half flash periods
// ----------------------------------------
`define NST_SETUP_HALVES 4'h6
`define NST_SETUP_ILV_HALVES 4'h3
`define NST_ASYM_CYCLE_HALVES 4'h4
`define NST_SYM_CYCLE_HALVES 4'h2
`define NST_ASYM_WR_LOW_HALVES 4'h2
`define NST_ASYM_RD_LOW_HALVES 4'h3
`define NST_SYM_LOW_HALVES 4'h1
`define NST_ASYM_HOLD_HALVES 4'h4
`define NST_SYM_HOLD_HALVES 4'h3

`endif

// [src/nst_fifo.v]
// Purpose: synchronous fifo with valid/ready on both sides
// Assumes: single clock, depth a power of two
// Notes: storage is flip-flops
`timescale 1ns/1ps
module nst_fifo #(
    parameter W = 10,
    parameter D = 16,
    parameter AW = 4
) (
    input wire pclk,
    input wire presetn,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data,
    output wire [AW:0] level
);
    reg [W-1:0] mem_r [0:D-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;

    assign in_ready = (cnt_r != D[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rp_r];
    assign level = cnt_r;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // ----------------------------------------
    // pointers and count
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            if (push & ~pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop & ~push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    // ----------------------------------------
    // storage
    // ----------------------------------------
    always @(posedge pclk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule // nst_fifo

// [test/nst_checker.sv]
// Purpose: port checker for nst_top
// Assumes: one clock, reset active low
// Notes: bound at foot
`timescale 1ns/1ps
module nst_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [7:0] nand_data_o,
    input wire nand_data_oe,
    input wire nand_ce_n,
    input wire nand_cle,
    input wire nand_ale,
    input wire nand_write_strobe_n,
    input wire read_strobe_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire idle_w = nand_write_strobe_n & read_strobe_n;
    sequence strobes_idle;
        idle_w [*3];
    endsequence
    sequence access_open;
        !nand_ce_n && !$past(nand_ce_n);
    endsequence
    // ----------------------------------------
    // apb side
    // ----------------------------------------
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    // ----------------------------------------
    // nand side
    // ----------------------------------------
    a_strobe_excl: assert property (!nand_write_strobe_n |-> read_strobe_n) else $error("both strobes low");
    a_strobe_in_ce: assert property (!idle_w |-> !nand_ce_n) else $error("strobe without ce");
    a_read_no_oe: assert property (!read_strobe_n |-> !nand_data_oe && !nand_cle && !nand_ale) else $error("read driven");
    a_access_stable: assert property (access_open |-> $stable(nand_data_o) && $stable(nand_data_oe)
        && $stable(nand_cle) && $stable(nand_ale)) else $error("access fields moved");
    a_ce_setup: assert property ($fell(nand_ce_n) |-> strobes_idle) else $error("ce setup short");
    a_ce_hold: assert property ($rose(nand_ce_n) |-> $past(idle_w) && $past(idle_w, 2)) else $error("ce hold short");
endmodule // nst_checker
bind nst_top nst_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .nand_data_o(nand_data_o),
    .nand_data_oe(nand_data_oe), .nand_ce_n(nand_ce_n), .nand_cle(nand_cle), .nand_ale(nand_ale),
    .nand_write_strobe_n(nand_write_strobe_n), .read_strobe_n(read_strobe_n));

// [test/nst_flash_model.sv]
// Purpose: behavioural nand flash device
// Assumes: byte wide bus
// Notes: released bus shows inverted data
`timescale 1ns/1ps
module nst_flash_model #(
    parameter HOLD = 60
) (
    input wire ce_n,
    input wire cle,
    input wire ale,
    input wire we_n,
    input wire re_n,
    input wire [7:0] data_o,
    input wire oe,
    input wire busy,
    output wire [7:0] data_i,
    output wire rb
);
    reg drive_r = 1'b0;
    reg [7:0] log_byte = 8'h00;
    reg [1:0] log_kind = 2'h0;
    integer wr_count = 0;
    always @(posedge we_n) begin
        if (ce_n === 1'b0) begin
            log_byte = data_o;
            log_kind = cle ? 2'h0 : (ale ? 2'h1 : 2'h2);
            wr_count = wr_count + 1;
        end
    end
    always @(negedge re_n) drive_r = (ce_n === 1'b0);
    always @(posedge re_n) drive_r <= #HOLD 1'b0;
    assign data_i = oe ? data_o : (drive_r ? 8'hC3 : 8'h3C);
    assign rb = ~busy;
endmodule // nst_flash_model

// [test/tb_top.sv]
// Purpose: self-checking bench of nst_top
// Assumes: apb master tasks
// Notes: pclk 100 MHz
`timescale 1ns/1ps
`include "nst_consts.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg fuse = 1'b0;
    reg busy = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, rb, oe, ce_n, cle, ale, we_n, re_n, fclk;
    wire [7:0] d_i, d_o;
    reg [31:0] rd_d;
    reg rd_e;
    integer checks = 0, failures = 0, cyc = 0, i, p, s1, t0;
    integer ce_t = 0, wl_t = 0, rl_t = 0, wlow = 0, rlow = 0, setup = 0;
    nst_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .boot_clock_select_fuse(fuse), .ready_busy_input(rb), .nand_data_i(d_i), .nand_data_o(d_o),
        .nand_data_oe(oe), .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale),
        .nand_write_strobe_n(we_n), .read_strobe_n(re_n), .flash_clk(fclk));
    nst_flash_model u_flash (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
        .data_o(d_o), .oe(oe), .busy(busy), .data_i(d_i), .rb(rb));
    // ----------------------------------------
    // clock, timeout, strobe timing monitor
    // ----------------------------------------
    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            stop_test;
        end
    end
    always @(negedge ce_n) ce_t = $time / 10;
    always @(negedge we_n) begin
        wl_t = $time / 10;
        setup = wl_t - ce_t;
    end
    always @(posedge we_n) wlow = $time / 10 - wl_t;
    always @(negedge re_n) rl_t = $time / 10;
    always @(posedge re_n) rlow = $time / 10 - rl_t;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task stop_test;
        begin
            $display("checks %0d failures %0d", checks, failures);
            if (failures == 0 && checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task apb(input reg w, input reg [7:0] a, input reg [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            do @(posedge pclk); while (pready !== 1'b1);
            rd_d = prdata;
            rd_e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task idle;
        begin
            do apb(1'b0, `NST_OFF_STATUS, 32'h0); while (rd_d[0] !== 1'b0 || rd_d[8:4] !== 5'h00);
        end
    endtask
    task per;
        begin
            @(posedge fclk);
            t0 = $time;
            @(posedge fclk);
            p = ($time - t0) / 10;
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        for (i = 0; i < 2; i++) begin
            fuse <= i[0];
            presetn <= 1'b0;
            repeat (6) @(posedge pclk);
            presetn <= 1'b1;
            repeat (4) @(posedge pclk);
            apb(1'b0, `NST_OFF_CLKDIV, 32'h0);
            `CHK("clkdiv", i ? `NST_DIV_FUSE_HIGH : `NST_DIV_FUSE_LOW, rd_d[3:0])
            per;
            `CHK("fclk period", i ? 7 : 3, p)
        end
        apb(1'b0, `NST_OFF_DELAY, 32'h0);
        `CHK("delay reset", `NST_DELAY_RST, rd_d[1:0])
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped err", 1'b1, rd_e)
        `CHK("unmapped data", 32'h0, rd_d)
        apb(1'b1, `NST_OFF_CLKDIV, 32'h4);
        per;
        `CHK("fclk period", 4, p)
        apb(1'b1, `NST_OFF_DELAY, 32'h3);
        apb(1'b0, `NST_OFF_DELAY, 32'h0);
        `CHK("delay code", 2'h3, rd_d[1:0])
        for (i = 0; i < 3; i++) begin
            apb(1'b1, `NST_OFF_CMD, {22'h0, i[1:0], 8'h50 + i[7:0]});
            idle;
            `CHK("kind", i[1:0], u_flash.log_kind)
            `CHK("byte", 8'h50 + i[7:0], u_flash.log_byte)
        end
        `CHK("asym write low", 4, wlow)
        busy <= 1'b1;
        apb(1'b1, `NST_OFF_CTRL, 32'h8);
        apb(1'b1, `NST_OFF_CMD, 32'h300);
        repeat (60) @(posedge pclk);
        `CHK("read held busy", 1'b1, re_n)
        busy <= 1'b0;
        idle;
        `CHK("asym read low", 6, rlow)
        apb(1'b0, `NST_OFF_RDATA, 32'h0);
        `CHK("read data", 8'hC3, rd_d[7:0])
        apb(1'b1, `NST_OFF_CTRL, 32'h1);
        apb(1'b1, `NST_OFF_CMD, 32'h211);
        idle;
        `CHK("sym write low", 2, wlow)
        s1 = setup;
        apb(1'b1, `NST_OFF_CMD, 32'h300);
        idle;
        `CHK("sym read low", 2, rlow)
        apb(1'b1, `NST_OFF_CTRL, 32'h3);
        apb(1'b1, `NST_OFF_CMD, 32'h222);
        idle;
        `CHK("interleave setup", 6, s1 - setup)
        apb(1'b1, `NST_OFF_CLKDIV, 32'hF);
        p = u_flash.wr_count;
        for (i = 0; i < 19; i++) begin
            t0 = $time;
            apb(1'b1, `NST_OFF_CMD, 32'h200 + i);
        end
        `CHK("refused write waits", 1'b1, ($time - t0) / 10 > 20)
        apb(1'b0, `NST_OFF_STATUS, 32'h0);
        `CHK("fifo level", 5'h10, rd_d[8:4])
        idle;
        `CHK("write count", 19, u_flash.wr_count - p)
        `CHK("last byte", 8'h12, u_flash.log_byte)
        stop_test;
    end
endmodule // tb_top
